// ==== hw/oxa_ctrl.sv ====
// Alarm, autorange and analog output controller of the oxygen analyzer
//
// Notes on behaviour
// - Each of two alarms holds setpoint, direction, defeat, failsafe and latching.
// - Defeat on-then-off, or latching off-then-on, in two key steps clears latch.
// - Holding an up or down key repeats steps at a faster rate.
// - Three ranges low, medium, high, each from zero to a set upper value.
// - Upper values default to 1.00, 5.00 and 10.00 percent.
// - Range mode comes out of reset as automatic.
// - Auto: above the active upper value, step to the next higher range.
// - Auto: slightly under the lower range's full scale, step down to it.
// - Auto: above the highest range, go to the zero to 25 percent range.
// - Crossing 25 percent alone never selects the calibration range.
// - Back within the highest range, calibration range returns to highest.
// - In the calibration range the reported reading is clamped to 25 percent.
// - Range mode is automatic or fixed low, medium or high.
// - Fixed range over its upper value saturates the output at full scale.
// - The concentration register always shows the true reading.
// - Output linear: zero is 0 V or 4 mA, upper value is 1 V or 20 mA.
// - Range ID levels 0.25, 0.50, 0.75, 1.00 V or 8, 12, 16, 20 mA.
// - Configuration done or measure key returns to the measuring state.
// - High alarm trips above setpoint, low alarm trips below it.
// - Failsafe de-energizes the relay in alarm, non-failsafe energizes it.
// - Latching alarm holds until reset; non-latching follows the condition.
// - A defeated alarm never activates its relay.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module oxa_ctrl
   import oxa_pkg::*;
#(
   parameter int HOLD_CYC = KEY_HOLD_CYC,
   parameter int RPT_CYC  = KEY_RPT_CYC
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   // Front-panel keys, levels
   input  wire logic              key_up,
   input  wire logic              key_down,
   input  wire logic              key_measure,
   // Measured concentration, 0.01 % units
   input  wire logic [15:0]       conc,
   // Relays, analog outputs, reported reading and measuring flag
   output logic      [1:0]        relay_energize,
   output oxa_analog_t            analog_out,
   output logic      [15:0]       reading,
   output logic                   measuring
);

   ////////////////////////////////////////////////////////////////////////////////
   // Settings and state
   oxa_state_t  state;
   oxa_mode_t   mode;
   oxa_range_t  rng;
   oxa_alarm_t  al [2];
   logic [15:0] rng_up [3];
   logic [3:0]  tgt;
   logic [1:0]  alarm_q;
   logic        last_ok;
   logic [3:0]  last_tgt;
   logic        last_val;

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire wr_ctrl  = reg_wr & (reg_addr == REG_CTRL);
   wire go_cfg   = wr_ctrl & reg_wdata[CTRL_START_BIT];
   wire go_done  = wr_ctrl & reg_wdata[CTRL_DONE_BIT];

   oxa_state_t next_state;
   always_comb begin
      next_state = state;
      if (key_measure || go_done) begin
         next_state = ST_MEASURE;
      end else if (go_cfg) begin
         next_state = ST_CONFIG;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Key repeat: first step on press, then after the hold time at the fast rate
   logic        key_prev;
   logic        fast;
   logic [31:0] kcnt;
   wire         key_one  = key_up ^ key_down;
   wire         key_edge = key_one & ~key_prev;
   wire  [31:0] kcnt_lim = fast ? 32'(RPT_CYC - 1) : 32'(HOLD_CYC - 1);
   wire         kcnt_end = key_one & ~key_edge & (kcnt == kcnt_lim);
   wire         key_step = (state == ST_CONFIG) & (key_edge | kcnt_end);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         key_prev <= 1'b0;
         fast     <= 1'b0;
         kcnt     <= 32'h0000_0000;
      end else begin
         key_prev <= key_one;
         if (!key_one || key_edge) begin
            kcnt <= 32'h0000_0000;
            fast <= 1'b0;
         end else if (kcnt_end) begin
            kcnt <= 32'h0000_0000;
            fast <= 1'b1;
         end else begin
            kcnt <= kcnt + 32'h0000_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Key steps on the selected setting
   wire       tgt_al  = (tgt[2:0] <= P_LTCH);
   wire       tgt_ai  = tgt[3];
   wire       tgt_rng = (tgt == T_RNG_LO) | (tgt == T_RNG_MED) | (tgt == T_RNG_HI);
   wire [1:0] rng_ix  = 2'(tgt[1:0] - 2'h1);
   wire       same_as_last = last_ok & (last_tgt == tgt);

   oxa_alarm_t  next_al [2];
   logic [15:0] next_up [3];
   oxa_mode_t   next_mode;
   logic [1:0]  lat_clr;
   logic        step_val;

   always_comb begin
      next_al   = al;
      next_up   = rng_up;
      next_mode = mode;
      lat_clr   = 2'h0;
      step_val  = 1'b0;
      if (key_step && tgt_al) begin
         case (tgt[2:0])
            P_SP: begin
               next_al[tgt_ai].setpoint = oxa_adj(al[tgt_ai].setpoint, key_up,
                                                  16'h0000, CONC_MAX);
            end
            P_DIR: begin
               next_al[tgt_ai].dir_high = ~al[tgt_ai].dir_high;
               step_val = next_al[tgt_ai].dir_high;
            end
            P_DFT: begin
               next_al[tgt_ai].defeat = ~al[tgt_ai].defeat;
               step_val = next_al[tgt_ai].defeat;
               // Defeat went on, now off again
               lat_clr[tgt_ai] = same_as_last & last_val & ~step_val;
            end
            P_FS: begin
               next_al[tgt_ai].failsafe = ~al[tgt_ai].failsafe;
               step_val = next_al[tgt_ai].failsafe;
            end
            default: begin
               next_al[tgt_ai].latching = ~al[tgt_ai].latching;
               step_val = next_al[tgt_ai].latching;
               // Latching went off, now on again
               lat_clr[tgt_ai] = same_as_last & ~last_val & step_val;
            end
         endcase
      end else if (key_step && tgt_rng) begin
         // Lower bound one count keeps the scaling divisor non-zero
         next_up[rng_ix] = oxa_adj(rng_up[rng_ix], key_up, CONC_MIN_UP, CONC_MAX);
      end else if (key_step && (tgt == T_MODE)) begin
         next_mode = oxa_mode_t'(key_up ? 2'(mode + 2'h1) : 2'(mode - 2'h1));
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state    <= ST_MEASURE;
         tgt      <= 4'h0;
         mode     <= M_AUTO;
         al[0]    <= ALARM_RST;
         al[1]    <= ALARM_RST;
         rng_up[0] <= RNG_LO_RST;
         rng_up[1] <= RNG_MED_RST;
         rng_up[2] <= RNG_HI_RST;
         last_ok  <= 1'b0;
         last_tgt <= 4'h0;
         last_val <= 1'b0;
      end else begin
         state  <= next_state;
         al     <= next_al;
         rng_up <= next_up;
         mode   <= next_mode;
         if (wr_ctrl) begin
            tgt <= reg_wdata[CTRL_TGT_LSB +: 4];
         end
         if (key_step) begin
            last_ok  <= tgt_al;
            last_tgt <= tgt;
            last_val <= step_val;
         end else if (wr_ctrl || state == ST_MEASURE) begin
            last_ok <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alarm evaluation; set wins over a latch clear in the same cycle
   logic [1:0] cond;
   logic [1:0] next_alarm;
   logic [1:0] next_relay;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cond[i] = al[i].dir_high ? (conc > al[i].setpoint)
                                  : (conc < al[i].setpoint);
         next_alarm[i] = ~al[i].defeat &
                         (cond[i] | (al[i].latching & alarm_q[i] & ~lat_clr[i]));
         next_relay[i] = al[i].failsafe ? ~next_alarm[i] : next_alarm[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Range selection
   wire [16:0] conc_h  = {1'b0, conc} + {1'b0, RNG_HYST};
   wire        dn_med  = conc_h < {1'b0, rng_up[0]};
   wire        dn_hi   = conc_h < {1'b0, rng_up[1]};

   oxa_range_t next_rng;
   always_comb begin
      next_rng = rng;
      unique case (mode)
         M_FLO:  next_rng = R_LOW;
         M_FMED: next_rng = R_MED;
         M_FHI:  next_rng = R_HIGH;
         M_AUTO: begin
            unique case (rng)
               R_LOW: begin
                  if (conc > rng_up[0]) next_rng = R_MED;
               end
               R_MED: begin
                  if (conc > rng_up[1]) next_rng = R_HIGH;
                  else if (dn_med) next_rng = R_LOW;
               end
               R_HIGH: begin
                  // Calibration range only above the highest upper value
                  if (conc > rng_up[2]) next_rng = R_CAL;
                  else if (dn_hi) next_rng = R_MED;
               end
               R_CAL: begin
                  if (conc <= rng_up[2]) next_rng = R_HIGH;
               end
            endcase
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Analog scaling against the active range
   wire [15:0] cur_up = (rng == R_LOW)  ? rng_up[0] :
                        (rng == R_MED)  ? rng_up[1] :
                        (rng == R_HIGH) ? rng_up[2] : CAL_UP;
   wire [15:0] sat_c  = (conc > cur_up) ? cur_up : conc;
   wire [15:0] clamp_c = ((rng == R_CAL) && (conc > CAL_UP)) ? CAL_UP : conc;

   oxa_analog_t next_analog;
   always_comb begin
      next_analog.conc_mv = oxa_scale(sat_c, cur_up, MV_FS);
      next_analog.conc_ua = 16'(UA_ZERO + oxa_scale(sat_c, cur_up, UA_SPAN));
      unique case (rng)
         R_LOW:  begin next_analog.rid_mv = RID_LO_MV;  next_analog.rid_ua = RID_LO_UA;  end
         R_MED:  begin next_analog.rid_mv = RID_MED_MV; next_analog.rid_ua = RID_MED_UA; end
         R_HIGH: begin next_analog.rid_mv = RID_HI_MV;  next_analog.rid_ua = RID_HI_UA;  end
         R_CAL:  begin next_analog.rid_mv = RID_CAL_MV; next_analog.rid_ua = RID_CAL_UA; end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register read mux
   wire [31:0] rd_mux = (reg_addr == REG_CTRL)   ? {26'h0, 1'b0, state, tgt} :
                        (reg_addr == REG_STATUS) ? {23'h0, state, mode, rng,
                                                    relay_energize, alarm_q} :
                        (reg_addr == REG_AL1)    ? {12'h0, al[0]} :
                        (reg_addr == REG_AL2)    ? {12'h0, al[1]} :
                        (reg_addr == REG_RNG_LM) ? {rng_up[1], rng_up[0]} :
                        (reg_addr == REG_RNG_H)  ? {14'h0, mode, rng_up[2]} :
                        (reg_addr == REG_CONC)   ? {16'h0, conc} : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rng            <= R_LOW;
         alarm_q        <= 2'h0;
         relay_energize <= 2'h0;
         analog_out     <= '0;
         reading        <= 16'h0000;
         measuring      <= 1'b1;
         reg_rdata      <= 32'h0000_0000;
      end else begin
         rng            <= next_rng;
         alarm_q        <= next_alarm;
         relay_energize <= next_relay;
         analog_out     <= next_analog;
         reading        <= clamp_c;
         measuring      <= (next_state == ST_MEASURE);
         reg_rdata      <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_fixed_low_sel: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == M_FLO) |=> (rng == R_LOW))
      else $error("fixed low mode did not select low range");

   chk_auto_step_up: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == M_AUTO && rng == R_LOW && conc > rng_up[0]) |=> (rng == R_MED))
      else $error("auto range did not step up");

   chk_auto_step_down: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == M_AUTO && rng == R_MED && conc <= rng_up[1] && dn_med) |=> (rng == R_LOW))
      else $error("auto range did not step down");

   chk_cal_enter: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == M_AUTO && rng == R_HIGH && conc > rng_up[2]) |=> (rng == R_CAL))
      else $error("calibration range not entered");

   chk_cal_leave: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == M_AUTO && rng == R_CAL && conc <= rng_up[2]) |=> (rng == R_HIGH))
      else $error("calibration range not left");

   chk_cal_clamp: assert property (@(posedge clk) disable iff (sys_rst)
      (rng == R_CAL) |=> (reading <= CAL_UP))
      else $error("reading above 25 percent in calibration range");

   chk_fixed_sat: assert property (@(posedge clk) disable iff (sys_rst)
      (rng != R_CAL && conc > cur_up) |=> (analog_out.conc_mv == MV_FS))
      else $error("analog output not saturated");

   chk_range_id: assert property (@(posedge clk) disable iff (sys_rst)
      (rng == R_MED) |=> (analog_out.rid_mv == RID_MED_MV && analog_out.rid_ua == RID_MED_UA))
      else $error("wrong range id level");

   chk_relay_sense: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=> (relay_energize[0] == ($past(al[0].failsafe) ? ~alarm_q[0] : alarm_q[0])))
      else $error("relay polarity wrong");

   chk_defeat_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      al[0].defeat |=> !alarm_q[0])
      else $error("defeated alarm active");

   chk_latch_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (alarm_q[0] && al[0].latching && !al[0].defeat && !lat_clr[0]) |=> alarm_q[0])
      else $error("latched alarm dropped");

   chk_latch_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (lat_clr[0] && !cond[0]) |=> !alarm_q[0])
      else $error("latched alarm not cleared");

   chk_measure_key: assert property (@(posedge clk) disable iff (sys_rst)
      key_measure |=> measuring ##1 (state == ST_MEASURE))
      else $error("measure key did not return to measuring");

endmodule

// ==== hw/oxa_pkg.sv ====
// Shared constants, types and helpers for the oxygen alarm and autorange controller
package oxa_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Concentration in units of 0.01 % oxygen
   localparam int          CONC_W      = 16;
   localparam logic [15:0] CONC_MIN_UP = 16'h0001;
   localparam logic [15:0] CONC_MAX    = 16'h2710;
   localparam logic [15:0] RNG_LO_RST  = 16'h0064;
   localparam logic [15:0] RNG_MED_RST = 16'h01f4;
   localparam logic [15:0] RNG_HI_RST  = 16'h03e8;
   localparam logic [15:0] CAL_UP      = 16'h09c4;
   // Downward range step needs the reading this far under the lower full scale
   localparam logic [15:0] RNG_HYST    = 16'h0005;

   ////////////////////////////////////////////////////////////////////////////////
   // Analog codes: volts in mV, currents in uA
   localparam logic [15:0] MV_FS       = 16'h03e8;
   localparam logic [15:0] UA_ZERO     = 16'h0fa0;
   localparam logic [15:0] UA_SPAN     = 16'h3e80;
   localparam logic [15:0] RID_LO_MV   = 16'h00fa;
   localparam logic [15:0] RID_MED_MV  = 16'h01f4;
   localparam logic [15:0] RID_HI_MV   = 16'h02ee;
   localparam logic [15:0] RID_CAL_MV  = 16'h03e8;
   localparam logic [15:0] RID_LO_UA   = 16'h1f40;
   localparam logic [15:0] RID_MED_UA  = 16'h2ee0;
   localparam logic [15:0] RID_HI_UA   = 16'h3e80;
   localparam logic [15:0] RID_CAL_UA  = 16'h4e20;

   ////////////////////////////////////////////////////////////////////////////////
   // Key repeat timing
   localparam int CLK_KHZ     = 250000;
   localparam int KEY_HOLD_MS = 500;
   localparam int KEY_RPT_MS  = 50;
   localparam int KEY_HOLD_CYC = KEY_HOLD_MS * CLK_KHZ;
   localparam int KEY_RPT_CYC  = KEY_RPT_MS * CLK_KHZ;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses) and fields
   localparam int         ADDR_W     = 8;
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_AL1    = 8'h08;
   localparam logic [7:0] REG_AL2    = 8'h0c;
   localparam logic [7:0] REG_RNG_LM = 8'h10;
   localparam logic [7:0] REG_RNG_H  = 8'h14;
   localparam logic [7:0] REG_CONC   = 8'h18;
   localparam int CTRL_TGT_LSB   = 0;
   localparam int CTRL_START_BIT = 4;
   localparam int CTRL_DONE_BIT  = 5;

   // Key targets: bit 3 picks the alarm, low bits the alarm parameter
   localparam logic [2:0] P_SP   = 3'h0;
   localparam logic [2:0] P_DIR  = 3'h1;
   localparam logic [2:0] P_DFT  = 3'h2;
   localparam logic [2:0] P_FS   = 3'h3;
   localparam logic [2:0] P_LTCH = 3'h4;
   localparam logic [3:0] T_RNG_LO  = 4'h5;
   localparam logic [3:0] T_RNG_MED = 4'h6;
   localparam logic [3:0] T_RNG_HI  = 4'h7;
   localparam logic [3:0] T_MODE    = 4'hd;

   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      R_LOW  = 2'h0,
      R_MED  = 2'h1,
      R_HIGH = 2'h3,
      R_CAL  = 2'h2
   } oxa_range_t;

   typedef enum logic [1:0] {
      M_AUTO = 2'h0,
      M_FLO  = 2'h1,
      M_FMED = 2'h2,
      M_FHI  = 2'h3
   } oxa_mode_t;

   typedef enum logic {
      ST_MEASURE = 1'b0,
      ST_CONFIG  = 1'b1
   } oxa_state_t;

   typedef struct packed {
      logic        latching;
      logic        failsafe;
      logic        defeat;
      logic        dir_high;
      logic [15:0] setpoint;
   } oxa_alarm_t;

   localparam oxa_alarm_t ALARM_RST = '{1'b0, 1'b0, 1'b0, 1'b1, 16'h0000};

   typedef struct packed {
      logic [15:0] conc_mv;
      logic [15:0] conc_ua;
      logic [15:0] rid_mv;
      logic [15:0] rid_ua;
   } oxa_analog_t;

   // Linear scaling c * fs / up, up never zero
   function automatic logic [15:0] oxa_scale(input logic [15:0] c, input logic [15:0] up,
                                             input logic [15:0] fs);
      logic [31:0] prod;
      prod = c * fs;
      return 16'(prod / {16'h0000, up});
   endfunction

   // Saturating one-count step up or down
   function automatic logic [15:0] oxa_adj(input logic [15:0] v, input logic up_dir,
                                           input logic [15:0] lo, input logic [15:0] hi);
      if (up_dir) begin
         return (v >= hi) ? hi : 16'(v + 16'h0001);
      end
      return (v <= lo) ? lo : 16'(v - 16'h0001);
   endfunction

endpackage

// ==== test/oxa_keypad.sv ====
// Front-panel keypad model: holds one arrow key for a set number of cycles
`timescale 1ns/1ps
module oxa_keypad (
   // Clock
   input  wire logic       clk,
   // Press request from the bench
   input  wire logic       req,
   input  wire logic       dir_up,
   input  wire logic [7:0] len,
   // Keys towards the block, busy back to the bench
   output logic            key_up,
   output logic            key_down,
   output logic            busy
);
   logic [7:0] cnt = 8'h00;

   always_ff @(posedge clk) begin
      if (req) begin
         cnt <= len;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end
   end

   // Never both keys at once: the block would read that as no key
   assign busy     = (cnt != 8'h00);
   assign key_up   = busy & dir_up;
   assign key_down = busy & ~dir_up;
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the alarm and autorange controller
`timescale 1ns/1ps
module tb;
   import oxa_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, key_measure = 1'b0;
   logic req = 1'b0, dir_up = 1'b1, key_up, key_down, busy, measuring;
   logic [7:0]  reg_addr = 8'h00, len = 8'h01;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic [15:0] conc = 16'h0000, reading;
   logic [1:0]  relay_energize;
   oxa_analog_t analog_out;
   int num_errors = 0, cmp_count = 0;
   logic [3:0]  last_w = 4'hf;

   always #2 clk = ~clk;

   oxa_ctrl #(.HOLD_CYC(8), .RPT_CYC(3)) oxa_ctrl_i (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .key_up(key_up), .key_down(key_down),
      .key_measure(key_measure), .conc(conc), .relay_energize(relay_energize),
      .analog_out(analog_out), .reading(reading), .measuring(measuring));
   oxa_keypad oxa_keypad_i (.clk(clk), .req(req), .dir_up(dir_up), .len(len),
      .key_up(key_up), .key_down(key_down), .busy(busy));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Keep conc for 8 cycles so range, then outputs, settle
   task automatic set_conc(input logic [15:0] c);
      @(posedge clk);
      conc <= c;
      tick(8);
   endtask
   // One key hold on a target, then a gap so the next press is a new step;
   // CTRL is written only for a new target, as a write breaks a latch-clear pair
   task automatic press(input logic [3:0] tgt, input logic [7:0] n, input logic up);
      if (tgt != last_w) begin
         wr(REG_CTRL, {27'h0, 1'b1, tgt});
         last_w = tgt;
      end
      @(posedge clk);
      req <= 1'b1; len <= n; dir_up <= up;
      @(posedge clk);
      req <= 1'b0;
      // Let the keypad count load before busy is polled
      #1;
      for (int i = 0; i < 60 && busy === 1'b1; i++) tick(1);
      tick(3);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(REG_STATUS);
      chk("mode_range", {26'h0, d[7:4]}, 32'h0);
      rd(REG_RNG_LM);
      chk("uppers_lm", d, 32'h01f4_0064);
      rd(REG_RNG_H);
      chk("upper_h", {16'h0, d[15:0]}, 32'h3e8);
   endtask
   task automatic t_range;
      set_conc(16'd50);
      chk("conc_mv", analog_out.conc_mv, 32'd500);
      chk("conc_ua", analog_out.conc_ua, 32'd12000);
      chk("rid_lo", {analog_out.rid_mv, analog_out.rid_ua}, {16'd250, 16'd8000});
      set_conc(16'd300);
      chk("med_ua", {analog_out.conc_mv, analog_out.conc_ua}, {16'd600, 16'd13600});
      chk("rid_med", {analog_out.rid_mv, analog_out.rid_ua}, {16'd500, 16'd12000});
      set_conc(16'd3000);
      chk("rid_cal", {analog_out.rid_mv, analog_out.rid_ua}, {16'd1000, 16'd20000});
      chk("clamp", reading, 32'd2500);
      rd(REG_CONC);
      chk("true_conc", d, 32'd3000);
      set_conc(16'd900);
      chk("rid_hi", {analog_out.rid_mv, analog_out.rid_ua}, {16'd750, 16'd16000});
      set_conc(16'd496);
      chk("hyst_hold", analog_out.rid_mv, 32'd750);
      set_conc(16'd494);
      chk("step_down", analog_out.rid_mv, 32'd500);
      set_conc(16'd90);
      chk("step_low", analog_out.rid_mv, 32'd250);
   endtask
   task automatic t_alarm;
      press(4'h0, 8'd20, 1'b1);
      chk("config", measuring, 32'h0);
      rd(REG_AL1);
      // 20 held cycles, hold 8, repeat 3: steps on press, then at 8, 11, 14, 17
      chk("fast_steps", {16'h0, d[15:0]}, 32'd5);
      set_conc(16'd1000);
      chk("relay_on", relay_energize[0], 32'h1);
      chk("relay2_on", relay_energize[1], 32'h1);
      set_conc(16'd0);
      chk("relay_off", relay_energize[0], 32'h0);
      press(4'h3, 8'd1, 1'b1);
      set_conc(16'd1000);
      chk("fs_relay", relay_energize[0], 32'h0);
      press(4'h4, 8'd1, 1'b1);
      set_conc(16'd0);
      rd(REG_STATUS);
      chk("latched", d[0], 32'h1);
      rd(REG_AL1);
      chk("al1_flags", {28'h0, d[19:16]}, 32'hd);
      press(4'h2, 8'd1, 1'b1);
      press(4'h2, 8'd1, 1'b1);
      rd(REG_STATUS);
      chk("latch_clr", d[0], 32'h0);
      press(4'h2, 8'd1, 1'b1);
      set_conc(16'd1000);
      rd(REG_STATUS);
      chk("defeated", d[0], 32'h0);
   endtask
   task automatic t_fixed;
      press(T_MODE, 8'd1, 1'b1);
      set_conc(16'd300);
      chk("fx_sat", {analog_out.conc_mv, analog_out.conc_ua}, {16'd1000, 16'd20000});
      chk("fx_rid", analog_out.rid_mv, 32'd250);
      @(posedge clk);
      key_measure <= 1'b1;
      @(posedge clk);
      key_measure <= 1'b0;
      tick(2);
      chk("measure", measuring, 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #20000;
      num_errors++;
      give_verdict;
   end
   // Upper limits stay at their increasing defaults
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      tick(2);
      t_reset;
      t_range;
      t_alarm;
      t_fixed;
      give_verdict;
   end
endmodule
